//--- include/elm_pkg.sv
// Purpose: Shared constants for the four-channel E1 loopback and probe control block.
// Assumes: One 50 MHz clock; all pin inputs asynchronous to it.
// Notes:   Probe select codes and channel count live here.
package elm_pkg;

	localparam int unsigned NUM_CH     = 4;
	localparam int unsigned SEL_W      = 3;
	localparam int unsigned CH_IDX_W   = 2;
	localparam int unsigned CLK_MHZ    = 50;
	localparam int unsigned SYNC_STAGES = 2;
	// Per-channel pin vectors carried by the main synchroniser
	localparam int unsigned SYNC_VECS   = 8;
	// Probe paths: one receive and one transmit per channel
	localparam int unsigned NUM_PATHS   = 2 * NUM_CH;

	// Top select bit picks transmit side
	localparam int unsigned SEL_DIR_BIT = 2;
	localparam logic        SEL_DIR_RX  = 1'h0;
	localparam logic        SEL_DIR_TX  = 1'h1;

	// Loop type encoding on the loop type select pins
	localparam logic LOOP_LOCAL  = 1'h0;
	localparam logic LOOP_REMOTE = 1'h1;

	// Reset values of all registered outputs
	localparam logic RST_LEVEL = 1'h0;

	typedef enum {
		ELM_NORMAL,
		ELM_LOCAL_LOOP,
		ELM_REMOTE_LOOP
	} elm_loop_e;

endpackage : elm_pkg

//--- core/elm_sync.sv
// Purpose: Two-flip-flop synchroniser for a bundle of asynchronous pin levels.
// Assumes: Inputs are levels, not single-cycle pulses.
// Notes:   First stage feeds only the second stage.
module elm_sync
	import elm_pkg::*;
#(
	parameter int unsigned WIDTH = 1
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             nrst,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule : elm_sync

//--- core/elm_ctrl.sv
// Purpose: Loopback routing, signal-absent flags, transmit enables and probe output for four E1 channels.
// Assumes: Analog front end supplies NRZ data and raw loss flags; all pins asynchronous to clk.
// Notes:   Every pin is synchronised, so outputs lag inputs by three clocks.
module elm_ctrl
	import elm_pkg::*;
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              nrst,
	// Per-channel loop control pins
	input  wire logic [NUM_CH-1:0] loop_type_sel,
	input  wire logic [NUM_CH-1:0] loop_engage,
	// Transmit side from framer
	input  wire logic [NUM_CH-1:0] tx_plus_data,
	input  wire logic [NUM_CH-1:0] tx_minus_data,
	input  wire logic [NUM_CH-1:0] tx_timing_in,
	input  wire logic [NUM_CH-1:0] tx_driver_enable,
	// Receive side from line slicers
	input  wire logic [NUM_CH-1:0] rx_line_plus,
	input  wire logic [NUM_CH-1:0] rx_line_minus,
	input  wire logic [NUM_CH-1:0] loss_detect,
	// Probe control
	input  wire logic              probe_sel_bit0,
	input  wire logic              probe_sel_bit1,
	input  wire logic              probe_sel_bit2,
	input  wire logic              probe_out_enable,
	// Receive outputs to framer
	output logic      [NUM_CH-1:0] rx_plus_data,
	output logic      [NUM_CH-1:0] rx_minus_data,
	output logic      [NUM_CH-1:0] signal_absent,
	// Transmit line side outputs
	output logic      [NUM_CH-1:0] tx_line_plus,
	output logic      [NUM_CH-1:0] tx_line_minus,
	output logic      [NUM_CH-1:0] tx_line_oe,
	output logic      [NUM_CH-1:0] tx_timing_out,
	// Probe output as three-state pin
	output logic                   probe_out,
	output logic                   probe_out_oe
);

	// Main bundle: per-channel pin vectors, then select code, then probe enable
	localparam int unsigned IN_W = SYNC_VECS * NUM_CH + SEL_W + 1;

	logic [IN_W-1:0]   raw_in;
	logic [IN_W-1:0]   sync_in;
	logic [NUM_CH-1:0] s_type;
	logic [NUM_CH-1:0] s_engage;
	logic [NUM_CH-1:0] s_txp;
	logic [NUM_CH-1:0] s_txn;
	logic [NUM_CH-1:0] s_tclk;
	logic [NUM_CH-1:0] s_txen;
	logic [NUM_CH-1:0] s_rxp;
	logic [NUM_CH-1:0] s_rxn;
	logic [NUM_CH-1:0] s_loss;
	logic [SEL_W-1:0]  s_sel;
	logic              s_pen;

	assign raw_in = {loop_type_sel, loop_engage, tx_plus_data, tx_minus_data,
		tx_timing_in, tx_driver_enable, rx_line_plus, loss_detect,
		probe_sel_bit2, probe_sel_bit1, probe_sel_bit0, probe_out_enable};

	// Minus data of receive travels alongside the bundle for equal latency
	elm_sync #(
		.WIDTH(IN_W)
	) u_sync_main (
		.clk      (clk),
		.nrst     (nrst),
		.async_in (raw_in),
		.sync_out (sync_in)
	);

	elm_sync #(
		.WIDTH(NUM_CH)
	) u_sync_rxn (
		.clk      (clk),
		.nrst     (nrst),
		.async_in (rx_line_minus),
		.sync_out (s_rxn)
	);

	// Unpack in the same order as raw_in
	assign {s_type, s_engage, s_txp, s_txn, s_tclk, s_txen, s_rxp, s_loss, s_sel, s_pen} = sync_in;

	// Per-channel loop state
	elm_loop_e          loop_state [NUM_CH];
	logic [NUM_CH-1:0]  local_on;
	logic [NUM_CH-1:0]  remote_on;
	logic [NUM_CH-1:0]  next_rxp;
	logic [NUM_CH-1:0]  next_rxn;
	logic [NUM_CH-1:0]  next_txp;
	logic [NUM_CH-1:0]  next_txn;

	// Engage gates the loop; the type pin alone never loops a channel
	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			if (!s_engage[i]) begin
				loop_state[i] = ELM_NORMAL;
			end else if (s_type[i] == LOOP_REMOTE) begin
				loop_state[i] = ELM_REMOTE_LOOP;
			end else begin
				loop_state[i] = ELM_LOCAL_LOOP;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < NUM_CH; i++) begin
			case (loop_state[i])
				ELM_LOCAL_LOOP: begin
					local_on[i]  = 1'h1;
					remote_on[i] = 1'h0;
				end
				ELM_REMOTE_LOOP: begin
					local_on[i]  = 1'h0;
					remote_on[i] = 1'h1;
				end
				default: begin
					local_on[i]  = 1'h0;
					remote_on[i] = 1'h0;
				end
			endcase
		end
	end

	// Local loop feeds transmit data back to receive outputs
	assign next_rxp = (local_on & s_txp) | (~local_on & s_rxp);
	assign next_rxn = (local_on & s_txn) | (~local_on & s_rxn);
	// Remote loop sends received line data back out to the line
	assign next_txp = (remote_on & s_rxp) | (~remote_on & s_txp);
	assign next_txn = (remote_on & s_rxn) | (~remote_on & s_txn);

	// Probe path decode: the whole 3-bit code picks exactly one of eight paths
	logic [CH_IDX_W-1:0]  probe_ch;
	logic                 probe_dir;
	logic [NUM_CH-1:0]    ch_hot;
	logic                 rx_side;
	logic                 tx_side;
	logic [NUM_CH-1:0]    rx_path_nrz;
	logic [NUM_CH-1:0]    tx_path_nrz;
	logic [NUM_PATHS-1:0] path_hot;
	logic [NUM_PATHS-1:0] path_nrz;
	logic                 next_probe;

	// A path is the OR of its two NRZ rails, taken after loopback
	assign rx_path_nrz = next_rxp | next_rxn;
	assign tx_path_nrz = next_txp | next_txn;
	assign path_nrz    = {tx_path_nrz, rx_path_nrz};

	assign probe_ch    = s_sel[CH_IDX_W-1:0];
	assign probe_dir   = s_sel[SEL_DIR_BIT];
	assign ch_hot      = NUM_CH'(1) << probe_ch;
	assign rx_side     = (probe_dir == SEL_DIR_RX);
	assign tx_side     = (probe_dir == SEL_DIR_TX);
	// One-hot gating, so two paths can never mix on the probe
	assign path_hot    = {ch_hot & {NUM_CH{tx_side}}, ch_hot & {NUM_CH{rx_side}}};
	assign next_probe  = |(path_hot & path_nrz);

	// Receive outputs carry the looped or received rails
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rx_plus_data  <= {NUM_CH{RST_LEVEL}};
			rx_minus_data <= {NUM_CH{RST_LEVEL}};
		end else begin
			rx_plus_data  <= next_rxp;
			rx_minus_data <= next_rxn;
		end
	end

	// Line side follows loopback; the timing pin is only passed through
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_line_plus  <= {NUM_CH{RST_LEVEL}};
			tx_line_minus <= {NUM_CH{RST_LEVEL}};
			tx_timing_out <= {NUM_CH{RST_LEVEL}};
		end else begin
			tx_line_plus  <= next_txp;
			tx_line_minus <= next_txn;
			tx_timing_out <= s_tclk;
		end
	end

	// No persistence filter here: the analog detector already decides loss
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			signal_absent <= {NUM_CH{RST_LEVEL}};
		end else begin
			signal_absent <= s_loss;
		end
	end

	// Independent of loopback; low in reset keeps every line released
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tx_line_oe <= {NUM_CH{RST_LEVEL}};
		end else begin
			tx_line_oe <= s_txen;
		end
	end

	// Probe value keeps tracking while released; only the enable marks high-Z
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			probe_out    <= RST_LEVEL;
			probe_out_oe <= RST_LEVEL;
		end else begin
			probe_out    <= next_probe;
			probe_out_oe <= s_pen;
		end
	end

endmodule : elm_ctrl

//--- test/elm_ctrl_chk.sv
// Purpose: Port-level checks of the loopback and probe block.
// Assumes: Outputs follow inputs exactly three clocks later.
// Notes:   Checks start three clocks after each reset release.
module elm_ctrl_chk
	import elm_pkg::*;
(
	// Clock and reset
	input wire logic              clk, nrst,
	// Inputs watched
	input wire logic [NUM_CH-1:0] loop_type_sel, loop_engage, tx_plus_data, tx_minus_data,
	input wire logic [NUM_CH-1:0] tx_timing_in, tx_driver_enable, rx_line_plus, rx_line_minus, loss_detect,
	input wire logic              probe_sel_bit0, probe_sel_bit1, probe_sel_bit2, probe_out_enable,
	// Outputs watched
	input wire logic [NUM_CH-1:0] rx_plus_data, rx_minus_data, signal_absent, tx_line_plus,
	input wire logic [NUM_CH-1:0] tx_line_minus, tx_line_oe, tx_timing_out,
	input wire logic              probe_out, probe_out_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0]          warm;
	wire logic           ok   = warm == 2'h3;
	wire logic [NUM_CH-1:0] loc = loop_engage & ~loop_type_sel;
	wire logic [NUM_CH-1:0] rem = loop_engage & loop_type_sel;
	wire logic [7:0]     xr   = {loc, loc} & {tx_plus_data, tx_minus_data} | ~{loc, loc} & {rx_line_plus, rx_line_minus};
	wire logic [7:0]     xt   = {rem, rem} & {rx_line_plus, rx_line_minus} | ~{rem, rem} & {tx_plus_data, tx_minus_data};
	wire logic [1:0]     pidx = {probe_sel_bit1, probe_sel_bit0};
	// Pipeline still holds reset zeros for three clocks
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) warm <= 2'h0;
		else if (warm != 2'h3) warm <= warm + 2'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_rx_path: assert property (ok |-> {rx_plus_data, rx_minus_data} == $past(xr, 3))
		else $error("receive outputs wrong");
	a_tx_path: assert property (ok |-> {tx_line_plus, tx_line_minus} == $past(xt, 3))
		else $error("transmit line outputs wrong");
	a_loss_flag: assert property (ok |-> signal_absent == $past(loss_detect, 3))
		else $error("signal absent flag wrong");
	a_drv_enable: assert property (ok |-> tx_line_oe == $past(tx_driver_enable, 3))
		else $error("driver enable wrong");
	a_probe_oe: assert property (ok |-> probe_out_oe == $past(probe_out_enable, 3))
		else $error("probe enable wrong");
	a_probe_rx: assert property (ok && probe_out_oe && !$past(probe_sel_bit2, 3) |->
		probe_out == (rx_plus_data[$past(pidx, 3)] | rx_minus_data[$past(pidx, 3)]))
		else $error("probe receive path wrong");
	a_probe_tx: assert property (ok && probe_out_oe && $past(probe_sel_bit2, 3) |->
		probe_out == (tx_line_plus[$past(pidx, 3)] | tx_line_minus[$past(pidx, 3)]))
		else $error("probe transmit path wrong");
	a_timing_copy: assert property (ok |-> tx_timing_out == $past(tx_timing_in, 3))
		else $error("timing copy wrong");
endmodule : elm_ctrl_chk

bind elm_ctrl elm_ctrl_chk u_chk (
	.clk              (clk),
	.nrst             (nrst),
	.loop_type_sel    (loop_type_sel),
	.loop_engage      (loop_engage),
	.tx_plus_data     (tx_plus_data),
	.tx_minus_data    (tx_minus_data),
	.tx_timing_in     (tx_timing_in),
	.tx_driver_enable (tx_driver_enable),
	.rx_line_plus     (rx_line_plus),
	.rx_line_minus    (rx_line_minus),
	.loss_detect      (loss_detect),
	.probe_sel_bit0   (probe_sel_bit0),
	.probe_sel_bit1   (probe_sel_bit1),
	.probe_sel_bit2   (probe_sel_bit2),
	.probe_out_enable (probe_out_enable),
	.rx_plus_data     (rx_plus_data),
	.rx_minus_data    (rx_minus_data),
	.signal_absent    (signal_absent),
	.tx_line_plus     (tx_line_plus),
	.tx_line_minus    (tx_line_minus),
	.tx_line_oe       (tx_line_oe),
	.tx_timing_out    (tx_timing_out),
	.probe_out        (probe_out),
	.probe_out_oe     (probe_out_oe)
);

//--- test/elm_framer_model.sv
// Purpose: Framer side model driving the static control and transmit pins.
// Assumes: Changes just after each rising clock edge.
// Notes:   Random levels every clock to reach every mode and code.
module elm_framer_model
	import elm_pkg::*;
(
	input  wire logic              clk,
	output logic [NUM_CH-1:0] loop_type_sel, loop_engage, tx_plus_data, tx_minus_data, tx_timing_in,
	output logic [NUM_CH-1:0] tx_driver_enable,
	output logic              probe_sel_bit0, probe_sel_bit1, probe_sel_bit2, probe_out_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rz;
	initial {loop_type_sel, loop_engage, tx_plus_data, tx_minus_data, tx_timing_in, tx_driver_enable,
		probe_sel_bit2, probe_sel_bit1, probe_sel_bit0, probe_out_enable} = 28'h0;
	always @(posedge clk) begin
		#1;
		rz = 1'($urandom());
		{loop_type_sel, loop_engage, tx_plus_data, tx_minus_data, tx_timing_in, tx_driver_enable,
			probe_sel_bit2, probe_sel_bit1, probe_sel_bit0, probe_out_enable} = 28'($urandom());
		if (rz) tx_timing_in = 4'hf;
	end
endmodule : elm_framer_model

//--- test/e1_loopback_monitor_control_tb_top.sv
// Purpose: Random self-checking bench against a three-clock behavioural model.
// Assumes: Line side and loss inputs driven here, framer pins by the model.
// Notes:   Includes a reset in mid-run.
module e1_loopback_monitor_control_tb_top
	import elm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'h0, nrst = 1'h0, probe_sel_bit0, probe_sel_bit1, probe_sel_bit2, probe_out_enable;
	logic [NUM_CH-1:0] loop_type_sel, loop_engage, tx_plus_data, tx_minus_data, tx_timing_in, tx_driver_enable;
	logic [NUM_CH-1:0] rx_line_plus = 4'h0, rx_line_minus = 4'h0, loss_detect = 4'h0, rx_plus_data;
	logic [NUM_CH-1:0] rx_minus_data, signal_absent, tx_line_plus, tx_line_minus, tx_line_oe, tx_timing_out;
	logic probe_out, probe_out_oe, in_rst;
	logic [39:0] q[$];
	logic [39:0] s;
	logic [29:0] e, seen;
	int n_mismatch = 0, checked = 0;
	elm_ctrl uut (
		.clk              (clk),
		.nrst             (nrst),
		.loop_type_sel    (loop_type_sel),
		.loop_engage      (loop_engage),
		.tx_plus_data     (tx_plus_data),
		.tx_minus_data    (tx_minus_data),
		.tx_timing_in     (tx_timing_in),
		.tx_driver_enable (tx_driver_enable),
		.rx_line_plus     (rx_line_plus),
		.rx_line_minus    (rx_line_minus),
		.loss_detect      (loss_detect),
		.probe_sel_bit0   (probe_sel_bit0),
		.probe_sel_bit1   (probe_sel_bit1),
		.probe_sel_bit2   (probe_sel_bit2),
		.probe_out_enable (probe_out_enable),
		.rx_plus_data     (rx_plus_data),
		.rx_minus_data    (rx_minus_data),
		.signal_absent    (signal_absent),
		.tx_line_plus     (tx_line_plus),
		.tx_line_minus    (tx_line_minus),
		.tx_line_oe       (tx_line_oe),
		.tx_timing_out    (tx_timing_out),
		.probe_out        (probe_out),
		.probe_out_oe     (probe_out_oe)
	);
	elm_framer_model u_framer (
		.clk              (clk),
		.loop_type_sel    (loop_type_sel),
		.loop_engage      (loop_engage),
		.tx_plus_data     (tx_plus_data),
		.tx_minus_data    (tx_minus_data),
		.tx_timing_in     (tx_timing_in),
		.tx_driver_enable (tx_driver_enable),
		.probe_sel_bit0   (probe_sel_bit0),
		.probe_sel_bit1   (probe_sel_bit1),
		.probe_sel_bit2   (probe_sel_bit2),
		.probe_out_enable (probe_out_enable)
	);
	always #10 clk = ~clk;
	function automatic logic [29:0] model(input logic [39:0] v);
		logic [3:0] lt, le, tp, tm, ti, te, rp, rm, ld, l, r, orp, orm, otp, otm;
		logic [2:0] sel;
		logic en;
		{lt, le, tp, tm, ti, te, rp, rm, ld, sel, en} = v;
		l = le & ~lt;
		r = le & lt;
		orp = l & tp | ~l & rp;
		orm = l & tm | ~l & rm;
		otp = r & rp | ~r & tp;
		otm = r & rm | ~r & tm;
		return {orp, orm, ld, otp, otm, te, ti, en, en & (sel[2] ? otp[sel[1:0]] | otm[sel[1:0]] :
			orp[sel[1:0]] | orm[sel[1:0]])};
	endfunction : model
	task finish_test;
		if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	initial begin
		void'($urandom(87));
		for (int k = 0; k < 1200; k++) begin
			@(posedge clk);
			#1;
			in_rst = k < 2 || (k >= 600 && k < 602);
			nrst = !in_rst;
			{rx_line_plus, rx_line_minus, loss_detect} = 12'($urandom());
			#1;
			e = in_rst ? 30'h0 : model(q.pop_front());
			seen = {rx_plus_data, rx_minus_data, signal_absent, tx_line_plus, tx_line_minus, tx_line_oe,
				tx_timing_out, probe_out_oe, probe_out & e[1]};
			checked++;
			if (seen !== e) begin
				n_mismatch++;
				$display("ERROR outputs expected %h seen %h", e, seen);
			end
			s = {loop_type_sel, loop_engage, tx_plus_data, tx_minus_data, tx_timing_in, tx_driver_enable,
				rx_line_plus, rx_line_minus, loss_detect, probe_sel_bit2, probe_sel_bit1, probe_sel_bit0,
				probe_out_enable};
			if (in_rst) q = '{40'h0, 40'h0, 40'h0};
			else q.push_back(s);
		end
		finish_test();
	end
endmodule : e1_loopback_monitor_control_tb_top
